//--- sim/led_gain_thermal_config_chk.sv
// port assertions for the configuration block
`timescale 1ns/1ns
module led_cfg_chk #(
    parameter int STAGGER_CYC = 4
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic OVERTEMP_IN,
    input wire logic RELEASE_TEMP_IN,
    input wire logic OUTPUT_ENABLE_IN,
    input wire logic OVERTEMP_LIMITER_OUT,
    input wire logic THERMAL_ERROR_OUT,
    input wire logic [3:0] OUTPUT_CHANNEL_GROUP_OUT
);
    // ----------------------------------------
    // stagger and thermal checks
    // ----------------------------------------
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    a_group_start: assert property ($rose(OUTPUT_ENABLE_IN) |-> ##[1:8] OUTPUT_CHANNEL_GROUP_OUT[0])
        else $error("group 0 late");
    a_group_one: assert property ($rose(OUTPUT_CHANNEL_GROUP_OUT[0]) |->
        ##STAGGER_CYC $rose(OUTPUT_CHANNEL_GROUP_OUT[1])) else $error("group 1 step");
    a_group_two: assert property ($rose(OUTPUT_CHANNEL_GROUP_OUT[1]) |->
        ##STAGGER_CYC $rose(OUTPUT_CHANNEL_GROUP_OUT[2])) else $error("group 2 step");
    a_group_three: assert property ($rose(OUTPUT_CHANNEL_GROUP_OUT[2]) |->
        ##STAGGER_CYC $rose(OUTPUT_CHANNEL_GROUP_OUT[3])) else $error("group 3 step");
    a_group_drop: assert property ($fell(OUTPUT_ENABLE_IN) |-> ##[1:24] (OUTPUT_CHANNEL_GROUP_OUT == 4'h0))
        else $error("groups stay on");
    a_limit_release: assert property ((RELEASE_TEMP_IN && !OVERTEMP_IN) |->
        ##3 (!OVERTEMP_LIMITER_OUT && !THERMAL_ERROR_OUT)) else $error("limit held after release");
    a_flag_cause: assert property ($rose(THERMAL_ERROR_OUT) |-> $past(OVERTEMP_IN, 3))
        else $error("flag without overtemp");
    a_flag_clear: assert property ($fell(THERMAL_ERROR_OUT) |->
        $past(RELEASE_TEMP_IN, 3) && !$past(OVERTEMP_IN, 3)) else $error("flag cleared early");
endmodule : led_cfg_chk
bind led_gain_thermal_config led_cfg_chk #(.STAGGER_CYC(STAGGER_CYC)) led_cfg_chk_inst (
    .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .OVERTEMP_IN(OVERTEMP_IN),
    .RELEASE_TEMP_IN(RELEASE_TEMP_IN), .OUTPUT_ENABLE_IN(OUTPUT_ENABLE_IN),
    .OVERTEMP_LIMITER_OUT(OVERTEMP_LIMITER_OUT), .THERMAL_ERROR_OUT(THERMAL_ERROR_OUT),
    .OUTPUT_CHANNEL_GROUP_OUT(OUTPUT_CHANNEL_GROUP_OUT));

//--- sim/led_gain_thermal_config_tb_top.sv
// self-checking bench for the configuration block
`timescale 1ns/1ns
module led_gain_thermal_config_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, ot = 1'b0, rel = 1'b0, oe = 1'b0;
    logic sclk, serial_data_in, le, sdo, band, lim, err;
    logic [6:0] mant;
    logic [3:0] grp;
    logic [15:0] w, rd;
    logic [31:0] seed = 32'h2;
    int failures = 0, n_checks = 0;
    always #5 clk = ~clk;
    led_host_model led_host_model_inst (.clk_in(clk), .sdo_in(sdo), .sclk_out(sclk),
        .sdata_out(serial_data_in), .latch_out(le));
    led_gain_thermal_config led_gain_thermal_config_inst (.MCLK_IN(clk), .RST_N_IN(rst_n),
        .SERIAL_DATA_IN(serial_data_in), .SHIFT_CLOCK_IN(sclk), .LATCH_STROBE_IN(le), .OVERTEMP_IN(ot),
        .RELEASE_TEMP_IN(rel), .OUTPUT_ENABLE_IN(oe), .SERIAL_DATA_OUT(sdo),
        .CURRENT_BAND_SELECT_OUT(band), .GAIN_MANTISSA_OUT(mant), .OVERTEMP_LIMITER_OUT(lim),
        .THERMAL_ERROR_OUT(err), .OUTPUT_CHANNEL_GROUP_OUT(grp));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    function automatic logic [6:0] gain_code(input logic hc, input int g4);
        return 7'(hc ? (64 * g4 - 128) / 3 : (256 * g4 - 128) / 3);
    endfunction : gain_code
    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task wr(input logic [15:0] v);
        led_host_model_inst.xfer(v, 1);
        repeat (8) @(negedge clk);
    endtask : wr
    task wait_grp(input logic [3:0] v);
        for (int i = 0; i < 40 && grp !== v; i++) @(negedge clk);
        chk(16'(grp), 16'(v), "group enables");
    endtask : wait_grp
    initial begin
        #400000;
        failures++;
        $display("mismatch at %0t: timeout", $time);
        stop_test;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(16'({band, mant}), 16'h00AA, "reset gain");
        chk(16'({lim, err}), 16'h0000, "reset thermal");
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            seed = xorshift(seed);
            w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFD : (seed[15:0] & 16'hFFFD);
            wr(w);
            chk(16'({band, mant}), 16'(w[9:2]), "gain field");
        end
        wr({6'h00, 1'b1, gain_code(1'b1, 5), 2'b00});
        chk(16'(mant), 16'h0040, "gain formula");
        wr({6'h00, 1'b0, gain_code(1'b0, 1), 2'b00});
        chk(16'({band, mant}), 16'h002A, "low band gain");
        $display("test gain done");
        ot = 1'b1;
        repeat (10) @(negedge clk);
        chk(16'(err), 16'h0000, "flag while disarmed");
        wr(16'h0302);
        chk(16'({lim, err}), 16'h0003, "flag armed");
        led_host_model_inst.read_cfg(rd);
        chk(rd & 16'h43FE, 16'h4302, "readback");
        ot = 1'b0;
        rel = 1'b1;
        repeat (10) @(negedge clk);
        chk(16'({lim, err}), 16'h0000, "flag release");
        rel = 1'b0;
        $display("test thermal done");
        oe = 1'b1;
        wait_grp(4'hF);
        oe = 1'b0;
        wait_grp(4'h0);
        $display("test stagger done");
        stop_test;
    end
endmodule : led_gain_thermal_config_tb_top

//--- sim/led_host_model.sv
// host controller model driving the serial configuration link
`timescale 1ns/1ns
module led_host_model (
    input wire logic clk_in,
    input wire logic sdo_in,
    output logic sclk_out,
    output logic sdata_out,
    output logic latch_out
);
    // ----------------------------------------
    // bit and frame tasks, 90 ns shift period
    // ----------------------------------------
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        latch_out = 1'b0;
    end
    task automatic shift_bit(input logic b, input logic le);
        @(negedge clk_in);
        sdata_out = b;
        latch_out = le;
        repeat (4) @(negedge clk_in);
        sclk_out = 1'b1;
        repeat (4) @(negedge clk_in);
        sclk_out = 1'b0;
    endtask : shift_bit
    task automatic xfer(input logic [15:0] w, input int nl);
        for (int i = 15; i >= 0; i--) begin
            shift_bit(w[i], i < nl);
        end
        @(negedge clk_in);
        latch_out = 1'b0;
        // released line flips so a stale bit never looks valid
        sdata_out = ~sdata_out;
    endtask : xfer
    task automatic read_cfg(output logic [15:0] r);
        xfer(16'h0000, 2);
        repeat (6) @(negedge clk_in);
        r[15] = sdo_in;
        // serial out lags the shift by one rise, so the first rise repeats bit 15
        shift_bit(~sdata_out, 1'b0);
        for (int i = 14; i >= 0; i--) begin
            shift_bit(~sdata_out, 1'b0);
            r[i] = sdo_in;
        end
    endtask : read_cfg
endmodule : led_host_model

//--- src/led_cfg_map.svh
// constants for the driver configuration block
`ifndef LED_CFG_MAP_SVH
`define LED_CFG_MAP_SVH
`define CFG_WIDTH 16
`define CFG_BAND_BIT 9
`define CFG_MANT_HI 8
`define CFG_MANT_LO 2
`define CFG_TP_BIT 1
`define CFG_ERR_BIT 14
// gain field 8'b1100_0000 is G = 1.25; G = 1 is band 1 with mantissa 8'h2A (approx)
`define CFG_RESET 16'h02A8
`define STAGGER_NS 40
`define CLK_NS 10
`define STAGGER_CYC ((`STAGGER_NS + `CLK_NS - 1) / `CLK_NS)
`define LE_WRITE_CLKS 4'h1
`define LE_READ_CLKS 4'h2
`endif

//--- src/led_cfg_pkg.sv
// types for the driver configuration block
package led_cfg_pkg;
    typedef enum logic [1:0] {
        SH_IDLE,
        SH_SHIFT,
        SH_READ
    } shift_state_t;
endpackage : led_cfg_pkg

//--- src/led_gain_thermal_config.sv
// configuration register, gain decode, thermal limiter and output stagger
// ------------------------------------------------------------
// Functional notes
// - gain field is config bits 9..2, 256 levels
// - bit 9 selects current band: 0 low, 1 high
// - bits 8..2 are 7-bit unsigned mantissa, msb at bit 8
// - mantissa is (256G-128)/3 high band, (1024G-128)/3 low band
// - four output groups by index mod 4, each 40 ns later; here at turn-on only, turn-off steps one clock per group
// - bit 1 arms thermal protection, default disabled
// - armed and overheated: set error flag, limit current to 25%
// - below release threshold: clear flag, restore full current
// - error flag at bit E, readable via read command
// - after reset gain defaults near 1
// ------------------------------------------------------------
`timescale 1ns/1ns
`include "led_cfg_map.svh"
module led_gain_thermal_config #(
    parameter int STAGGER_CYC = `STAGGER_CYC
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic SERIAL_DATA_IN,
    input wire logic SHIFT_CLOCK_IN,
    input wire logic LATCH_STROBE_IN,
    input wire logic OVERTEMP_IN,
    input wire logic RELEASE_TEMP_IN,
    input wire logic OUTPUT_ENABLE_IN,
    output logic SERIAL_DATA_OUT,
    output logic CURRENT_BAND_SELECT_OUT,
    output logic [6:0] GAIN_MANTISSA_OUT,
    output logic OVERTEMP_LIMITER_OUT,
    output logic THERMAL_ERROR_OUT,
    output logic [3:0] OUTPUT_CHANNEL_GROUP_OUT
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    logic sclk_d_reg;
    logic [4:0] pins;
    assign pins = {SERIAL_DATA_IN, SHIFT_CLOCK_IN, LATCH_STROBE_IN, OVERTEMP_IN,
                   RELEASE_TEMP_IN};

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            s1_reg <= 5'h00;
            s2_reg <= 5'h00;
            sclk_d_reg <= 1'b0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            sclk_d_reg <= s2_reg[3];
        end
    end

    logic serial_data_in;
    logic sclk;
    logic le;
    logic hot;
    logic cool;
    logic sclk_rise;
    assign serial_data_in = s2_reg[4];
    assign sclk = s2_reg[3];
    assign le = s2_reg[2];
    assign hot = s2_reg[1];
    assign cool = s2_reg[0];
    assign sclk_rise = sclk & ~sclk_d_reg;

    // ------------------------------------------------------------
    // serial shift and configuration register
    // ------------------------------------------------------------
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    logic [3:0] le_cnt_reg;
    logic [3:0] le_cnt_next;
    logic err_reg;
    logic err_next;
    logic sdo_reg;
    logic sdo_next;
    led_cfg_pkg::shift_state_t st_reg;
    led_cfg_pkg::shift_state_t st_next;
    logic [15:0] cfg_view;

    // error flag always reads back live at bit E
    always_comb begin
        cfg_view = cfg_reg;
        cfg_view[`CFG_ERR_BIT] = err_reg;
    end

    always_comb begin
        shift_next = shift_reg;
        cfg_next = cfg_reg;
        le_cnt_next = le_cnt_reg;
        st_next = st_reg;
        sdo_next = sdo_reg;
        case (st_reg)
            led_cfg_pkg::SH_IDLE: begin
                if (sclk_rise) begin
                    shift_next = {shift_reg[14:0], serial_data_in};
                    sdo_next = shift_reg[15];
                end
                if (le) begin
                    le_cnt_next = 4'h0;
                    st_next = led_cfg_pkg::SH_SHIFT;
                end
            end
            led_cfg_pkg::SH_SHIFT: begin
                // command is the count of shift clock rises while latch is high
                if (sclk_rise) begin
                    shift_next = {shift_reg[14:0], serial_data_in};
                    le_cnt_next = le_cnt_reg + 4'h1;
                end
                if (!le) begin
                    st_next = led_cfg_pkg::SH_IDLE;
                    if (le_cnt_reg == `LE_WRITE_CLKS) begin
                        cfg_next = shift_reg;
                        cfg_next[`CFG_ERR_BIT] = 1'b0;
                    end else if (le_cnt_reg == `LE_READ_CLKS) begin
                        shift_next = cfg_view;
                        sdo_next = cfg_view[15];
                        st_next = led_cfg_pkg::SH_READ;
                    end
                end
            end
            led_cfg_pkg::SH_READ: begin
                st_next = led_cfg_pkg::SH_IDLE;
            end
            default: begin
                st_next = led_cfg_pkg::SH_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            shift_reg <= 16'h0000;
            cfg_reg <= `CFG_RESET;
            le_cnt_reg <= 4'h0;
            st_reg <= led_cfg_pkg::SH_IDLE;
            sdo_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            cfg_reg <= cfg_next;
            le_cnt_reg <= le_cnt_next;
            st_reg <= st_next;
            sdo_reg <= sdo_next;
        end
    end

    // ------------------------------------------------------------
    // thermal limiter
    // ------------------------------------------------------------
    // set wins over release if both indications show at once
    always_comb begin
        err_next = err_reg;
        if (!cfg_reg[`CFG_TP_BIT]) begin
            err_next = 1'b0;
        end else if (hot) begin
            err_next = 1'b1;
        end else if (cool) begin
            err_next = 1'b0;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= err_next;
        end
    end

    // ------------------------------------------------------------
    // output group stagger
    // ------------------------------------------------------------
    logic oe_s1_reg;
    logic oe_s2_reg;
    logic [4:0] chain;

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            oe_s1_reg <= 1'b0;
            oe_s2_reg <= 1'b0;
        end else begin
            oe_s1_reg <= OUTPUT_ENABLE_IN;
            oe_s2_reg <= oe_s1_reg;
        end
    end

    assign chain[0] = oe_s2_reg;

    // group 0 waits one stage too, but of one cycle, so its step is shorter than the STAGGER_CYC steps of groups 1 to 3
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_stage
            stagger_stage #(
                .DELAY_CYC(g == 0 ? 1 : STAGGER_CYC)
            ) u_stage (
                .clk_in(MCLK_IN),
                .rst_n_in(RST_N_IN),
                .en_in(chain[g]),
                .en_out(chain[g+1])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign SERIAL_DATA_OUT = sdo_reg;
    assign CURRENT_BAND_SELECT_OUT = cfg_reg[`CFG_BAND_BIT];
    assign GAIN_MANTISSA_OUT = cfg_reg[`CFG_MANT_HI:`CFG_MANT_LO];
    assign OVERTEMP_LIMITER_OUT = err_reg;
    assign THERMAL_ERROR_OUT = err_reg;
    assign OUTPUT_CHANNEL_GROUP_OUT = chain[4:1];
endmodule : led_gain_thermal_config

//--- src/stagger_stage.sv
// one delay stage of the output group stagger
`timescale 1ns/1ns
`include "led_cfg_map.svh"
module stagger_stage #(
    parameter int DELAY_CYC = `STAGGER_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic en_in,
    output logic en_out
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic en_reg;
    logic en_next;

    always_comb begin
        cnt_next = cnt_reg;
        en_next = en_reg;
        if (!en_in) begin
            cnt_next = 8'h00;
            en_next = 1'b0;
        end else if (cnt_reg < 8'(DELAY_CYC - 1)) begin
            cnt_next = cnt_reg + 8'h01;
        end else begin
            en_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 8'h00;
            en_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            en_reg <= en_next;
        end
    end

    assign en_out = en_reg;
endmodule : stagger_stage
